// ---- cmx_map.svh ----
// register offsets, field positions, reset values and select codes
`ifndef CMX_MAP_SVH
`define CMX_MAP_SVH
`define CMX_SFR_PAGE 4'h0
`define CMX_ADDR_CMP0 8'h9F
`define CMX_ADDR_CMP1 8'h9E
`define CMX_REG_RESET 8'hFF
`define CMX_NEG_MSB 7
`define CMX_NEG_LSB 4
`define CMX_POS_MSB 3
`define CMX_POS_LSB 0
`define CMX_CODE_COMPARE 4'hC
`define CMX_CODE_HALF_BAT 4'hD
`define CMX_CODE_E 4'hE
`define CMX_CODE_F 4'hF
`endif

// ---- cmx_pkg.sv ----
// types shared by the comparator input select block
package cmx_pkg;
	// one-hot analog switch controls for one multiplexer side
	typedef struct packed {
		logic [9:0] port_pin;
		logic compare;
		logic half_battery;
		logic digital_supply;
		logic ground;
		logic battery_supply;
		logic converter_supply;
	} cmx_mux_sel_t;
	typedef struct packed {
		logic [7:0] cmp0_sel_reg;
		logic [7:0] cmp1_sel_reg;
		logic [7:0] rdata_reg;
		cmx_mux_sel_t cmp0_pos_reg;
		cmx_mux_sel_t cmp0_neg_reg;
		cmx_mux_sel_t cmp1_pos_reg;
		cmx_mux_sel_t cmp1_neg_reg;
	} cmx_state_t;
endpackage : cmx_pkg

// ---- cmx_decode_if.sv ----
// carries one select field to a decoder and its switch controls back
`timescale 1ns/1ps
`default_nettype none
interface cmx_decode_if;
	import cmx_pkg::*;
	logic [3:0] code;
	cmx_mux_sel_t sel;
	modport requester (output code, input sel);
	modport decoder (input code, output sel);
endinterface : cmx_decode_if
`default_nettype wire

// ---- cmx_field_decode.sv ----
// decodes one 4-bit select field into one-hot analog switch controls
`timescale 1ns/1ps
`default_nettype none
`include "cmx_map.svh"
module cmx_field_decode import cmx_pkg::*; #(
	parameter bit POSITIVE = 1'b0,
	parameter bit CMP1 = 1'b0
) (
	cmx_decode_if.decoder dec
);
	always_comb begin
		dec.sel = '0;
		if (POSITIVE) begin
			// positive port pins use the even pins of each port
			case (dec.code)
				4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9: begin
					dec.sel.port_pin[dec.code] = 1'b1;
				end
				`CMX_CODE_COMPARE: dec.sel.compare = 1'b1;
				`CMX_CODE_HALF_BAT: dec.sel.half_battery = 1'b1;
				`CMX_CODE_E: dec.sel.battery_supply = 1'b1;
				`CMX_CODE_F: begin
					if (CMP1) begin
						dec.sel.converter_supply = 1'b1;
					end else begin
						dec.sel.battery_supply = 1'b1;
					end
				end
				// reserved codes open every switch
				default: dec.sel = '0;
			endcase
		end else begin
			case (dec.code)
				4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9: begin
					dec.sel.port_pin[dec.code] = 1'b1;
				end
				`CMX_CODE_COMPARE: dec.sel.compare = 1'b1;
				`CMX_CODE_HALF_BAT: dec.sel.half_battery = 1'b1;
				`CMX_CODE_E: dec.sel.digital_supply = 1'b1;
				`CMX_CODE_F: dec.sel.ground = 1'b1;
				default: dec.sel = '0;
			endcase
		end
	end
endmodule : cmx_field_decode
`default_nettype wire

// ---- cmx_select_regs.sv ----
// comparator input select registers and their multiplexer controls
// Operation
// - comparator0 select at 0x9F page 0, resets ones
// - comparator1 select at 0x9E page 0, resets ones
// - comparator0 bits 7:4 pick negative input
// - comparator0 bits 3:0 pick positive input
// - comparator1 negative decodes like comparator0 negative
// - comparator1 positive code 1111 picks converter supply
// - select codes drive the analog multiplexers
`timescale 1ns/1ps
`default_nettype none
`include "cmx_map.svh"
module cmx_select_regs import cmx_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic [7:0] comparator0_input_select,
	output logic [7:0] comparator1_input_select,
	output cmx_mux_sel_t cmp0_positive_select,
	output cmx_mux_sel_t cmp0_negative_select,
	output cmx_mux_sel_t cmp1_positive_select,
	output cmx_mux_sel_t cmp1_negative_select
);
	cmx_state_t st_reg;
	cmx_state_t st_next;
	logic hit0;
	logic hit1;
	logic [7:0] sel0_new;
	logic [7:0] sel1_new;
	cmx_decode_if d0p ();
	cmx_decode_if d0n ();
	cmx_decode_if d1p ();
	cmx_decode_if d1n ();

	cmx_field_decode #(.POSITIVE(1'b1), .CMP1(1'b0)) u_d0p (.dec(d0p));
	cmx_field_decode #(.POSITIVE(1'b0), .CMP1(1'b0)) u_d0n (.dec(d0n));
	cmx_field_decode #(.POSITIVE(1'b1), .CMP1(1'b1)) u_d1p (.dec(d1p));
	cmx_field_decode #(.POSITIVE(1'b0), .CMP1(1'b1)) u_d1n (.dec(d1n));

	assign hit0 = (sfr_page == `CMX_SFR_PAGE) && (sfr_addr == `CMX_ADDR_CMP0);
	assign hit1 = (sfr_page == `CMX_SFR_PAGE) && (sfr_addr == `CMX_ADDR_CMP1);

	// merge the write before decoding, so the switches move with the value
	// and the decode never loops back through st_next
	always_comb begin
		sel0_new = st_reg.cmp0_sel_reg;
		sel1_new = st_reg.cmp1_sel_reg;
		// reserved codes are stored untouched
		if (sfr_wr && hit0) begin
			sel0_new = sfr_wdata;
		end
		if (sfr_wr && hit1) begin
			sel1_new = sfr_wdata;
		end
		d0p.code = sel0_new[`CMX_POS_MSB:`CMX_POS_LSB];
		d0n.code = sel0_new[`CMX_NEG_MSB:`CMX_NEG_LSB];
		d1p.code = sel1_new[`CMX_POS_MSB:`CMX_POS_LSB];
		d1n.code = sel1_new[`CMX_NEG_MSB:`CMX_NEG_LSB];
	end

	always_comb begin
		st_next = st_reg;
		st_next.cmp0_sel_reg = sel0_new;
		st_next.cmp1_sel_reg = sel1_new;
		// unmapped reads return zero; read data stands one cycle
		if (sfr_rd && hit0) begin
			st_next.rdata_reg = st_reg.cmp0_sel_reg;
		end else if (sfr_rd && hit1) begin
			st_next.rdata_reg = st_reg.cmp1_sel_reg;
		end else begin
			st_next.rdata_reg = 8'h00;
		end
		st_next.cmp0_pos_reg = d0p.sel;
		st_next.cmp0_neg_reg = d0n.sel;
		st_next.cmp1_pos_reg = d1p.sel;
		st_next.cmp1_neg_reg = d1n.sel;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.cmp0_sel_reg <= `CMX_REG_RESET;
			st_reg.cmp1_sel_reg <= `CMX_REG_RESET;
			st_reg.cmp0_pos_reg.battery_supply <= 1'b1;
			st_reg.cmp0_neg_reg.ground <= 1'b1;
			st_reg.cmp1_pos_reg.converter_supply <= 1'b1;
			st_reg.cmp1_neg_reg.ground <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sfr_rdata = st_reg.rdata_reg;
	assign comparator0_input_select = st_reg.cmp0_sel_reg;
	assign comparator1_input_select = st_reg.cmp1_sel_reg;
	assign cmp0_positive_select = st_reg.cmp0_pos_reg;
	assign cmp0_negative_select = st_reg.cmp0_neg_reg;
	assign cmp1_positive_select = st_reg.cmp1_pos_reg;
	assign cmp1_negative_select = st_reg.cmp1_neg_reg;
endmodule : cmx_select_regs
`default_nettype wire

// ---- cmx_select_regs_assertions.sv ----
// checker of the comparator input select registers
`timescale 1ns/1ps
`default_nettype none
module cmx_select_regs_assertions import cmx_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sfr_wr,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] comparator0_input_select,
	input wire logic [7:0] comparator1_input_select,
	input wire cmx_mux_sel_t cmp0_positive_select,
	input wire cmx_mux_sel_t cmp0_negative_select,
	input wire cmx_mux_sel_t cmp1_positive_select,
	input wire cmx_mux_sel_t cmp1_negative_select
);
	wire logic w = sfr_wr && sfr_page == 4'h0;
	wire logic [7:0] c = comparator0_input_select;
	wire logic [7:0] d = comparator1_input_select;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_write_sel0: assert property (w && sfr_addr == 8'h9F |=>
		c == $past(sfr_wdata)) else $error("write 0 lost");
	a_write_sel1: assert property (w && sfr_addr == 8'h9E |=>
		d == $past(sfr_wdata)) else $error("write 1 lost");
	a_neg0_ground: assert property (c[7:4] == 4'hF |->
		cmp0_negative_select == 16'h0004) else $error("neg 0");
	a_pos0_battery: assert property (c[3:1] == 3'h7 |->
		cmp0_positive_select == 16'h0002) else $error("pos 0");
	a_neg1_pin: assert property (d[7:4] inside {[4'h6:4'h9]} |->
		cmp1_negative_select == 16'h0040 << d[7:4]) else $error("neg 1");
	a_pos1_conv: assert property (d[3:0] == 4'hF |->
		cmp1_positive_select == 16'h0001) else $error("pos 1");
	a_write_hold: assert property (!w |=> $stable(c) && $stable(d))
		else $error("changed");
	a_reserved_none: assert property (c[3:0] inside {4'h4, 4'hA} |->
		cmp0_positive_select == 16'h0000) else $error("reserved");
endmodule : cmx_select_regs_assertions
bind cmx_select_regs cmx_select_regs_assertions chk (
	.mclk(mclk),
	.reset(reset),
	.sfr_wr(sfr_wr),
	.sfr_page(sfr_page),
	.sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata),
	.comparator0_input_select(comparator0_input_select),
	.comparator1_input_select(comparator1_input_select),
	.cmp0_positive_select(cmp0_positive_select),
	.cmp0_negative_select(cmp0_negative_select),
	.cmp1_positive_select(cmp1_positive_select),
	.cmp1_negative_select(cmp1_negative_select)
);
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the comparator input select registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic [3:0] sfr_page = 4'h0;
	logic [7:0] sfr_addr = 8'h9F, sfr_wdata = 8'h00, sfr_rdata, m[2];
	wire logic [79:0] o;
	wire logic hit = sfr_page == 4'h0 && sfr_addr != 8'h9D;
	int n_mismatch = 0, n_compared = 0, seed = 81237;
	always #10 mclk = ~mclk;
	cmx_select_regs dut (.mclk, .reset, .sfr_page, .sfr_addr, .sfr_wr,
		.sfr_rd, .sfr_wdata, .sfr_rdata, .comparator0_input_select(o[79:72]),
		.comparator1_input_select(o[71:64]), .cmp0_positive_select(o[63:48]),
		.cmp0_negative_select(o[47:32]), .cmp1_positive_select(o[31:16]),
		.cmp1_negative_select(o[15:0]));
	function automatic logic [15:0] dec(logic [3:0] c, bit p, bit one);
		logic [15:0] hi[4] = '{16'h0020, 16'h0010, p ? 16'h0002 : 16'h0008,
			p ? (one ? 16'h0001 : 16'h0002) : 16'h0004};
		if (c > 4'hB)
			return hi[c[1:0]];
		return c inside {4'h4, 4'h5, 4'hA, 4'hB} || (!p && c == 4'h3) ?
			16'h0000 : 16'h0040 << c;
	endfunction : dec
	task automatic chk(logic [87:0] got, exp);
		n_compared++;
		if (got !== exp)
			$display("wrong value at %0t: %h", $time, got);
		n_mismatch += int'(got !== exp);
	endtask : chk
	task automatic check_all(logic [7:0] rd);
		chk({o, sfr_rdata}, {m[0], m[1], dec(m[0][3:0], 1, 0),
			dec(m[0][7:4], 0, 0), dec(m[1][3:0], 1, 1),
			dec(m[1][7:4], 0, 1), rd});
	endtask : check_all
	task print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		#20000 n_mismatch++;
		print_verdict;
	end
	initial begin
		m = '{2{8'hFF}};
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		#1 check_all(8'h00);
		// first 32 writes sweep every code through both fields of both registers
		for (int i = 0; i < 80; i++) begin
			@(posedge mclk) sfr_wr <= 1'b1;
			sfr_page <= i > 32 && i % 7 == 3 ? 4'h2 : 4'h0;
			sfr_addr <= i > 32 && i % 5 == 4 ? 8'h9D :
				{7'h4F, i > 31 ? i[0] : !i[4]};
			// reserved codes break the software rule on purpose
			sfr_wdata <= i < 32 ? {i[3:0], ~i[3:0]} : 8'($random(seed));
			@(posedge mclk) sfr_wr <= 1'b0;
			sfr_rd <= 1'b1;
			if (hit)
				m[!sfr_addr[0]] = sfr_wdata;
			@(posedge mclk) sfr_rd <= 1'b0;
			#1 check_all(hit ? m[!sfr_addr[0]] : 8'h00);
		end
		print_verdict;
	end
endmodule : tb_top
`default_nettype wire
